/* File: fri_pkg.sv */
// shared constants and types for the flash resume, power-down and id command block
package fri_pkg;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_SUSPEND  = 8'h75;
	localparam logic [7:0] OP_RESUME   = 8'h7a;
	localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
	localparam logic [7:0] OP_RELEASE  = 8'hab;
	localparam logic [7:0] OP_ID_MD    = 8'h90;
	localparam logic [7:0] OP_ID_DUAL  = 8'h92;
	localparam logic [7:0] OP_ID_QUAD  = 8'h94;
	localparam logic [7:0] OP_UID      = 8'h4b;
	localparam logic [7:0] OP_JEDEC    = 8'h9f;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int PD_ENTRY_NS    = 3000;
	localparam int PD_RELEASE_NS  = 3000;
	localparam int RESUME_BUSY_NS = 200;
	// longest times round down, least times round up
	localparam int PD_ENTRY_CYC    = (PD_ENTRY_NS * 1000) / CLK_PERIOD_PS;
	localparam int PD_RELEASE_CYC  = (PD_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RESUME_BUSY_CYC = (RESUME_BUSY_NS * 1000) / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// frame layout: rising edges before the data phase, data lengths, lanes, output enables
	// ------------------------------------------------------------
	localparam logic [6:0] OPC_BITS  = 7'h08;
	localparam logic [6:0] START_AB  = 7'h20;
	localparam logic [6:0] START_MD  = 7'h20;
	localparam logic [6:0] START_DL  = 7'h18;
	localparam logic [6:0] START_QD  = 7'h14;
	localparam logic [6:0] START_UID = 7'h28;
	localparam logic [6:0] START_JD  = 7'h08;
	localparam logic [6:0] LEN_8     = 7'h08;
	localparam logic [6:0] LEN_16    = 7'h10;
	localparam logic [6:0] LEN_24    = 7'h18;
	localparam logic [6:0] LEN_64    = 7'h40;
	localparam logic [6:0] LANES_1   = 7'h01;
	localparam logic [6:0] LANES_2   = 7'h02;
	localparam logic [6:0] LANES_4   = 7'h04;
	localparam logic [3:0] OE_1      = 4'h2;
	localparam logic [3:0] OE_2      = 4'h3;
	localparam logic [3:0] OE_4      = 4'hf;
	localparam logic [5:0] PIN_RST   = 6'h10;

	typedef enum logic [1:0] {PW_ACTIVE, PW_ENTER, PW_DOWN, PW_RELEASE} fri_pwr_t;
	typedef enum logic [1:0] {CM_OPCODE, CM_WAIT, CM_DATA, CM_IGNORE} fri_cmd_t;

endpackage : fri_pkg

/* File: fri_sync.sv */
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module fri_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= RST_VAL;
			dout   <= RST_VAL;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : fri_sync

/* File: fri_cmd.sv */
// serial flash resume, power-down and identification command block
// What this block does
// - resume accepted only with suspend flag set and not busy, else dropped
// - accepted resume clears suspend flag at once, busy within 200 ns
// - resume ignored after power loss cut the suspended operation short
// - power-down is B9h alone; chip select must rise right after bit eight
// - power-down state reached within entry time after chip select rises
// - while powered down only ABh is recognised, all else ignored
// - device always starts in normal operation
// - release takes effect at chip select high; no command during release delay
// - ABh plus three dummy bytes shifts device byte out msb first
// - device byte repeats while clocks continue, ends at chip select high
// - ABh ignored entirely while busy
// - 90h plus zero address gives manufacturer then device byte
// - 92h gives alternating id bytes two bits per clock
// - 94h, four dummy clocks, address, then id bytes four bits per clock
// - 4Bh plus four dummy bytes gives 64-bit unique number
// - 9Fh gives manufacturer, memory type and capacity bytes msb first
// - opcode bits captured on rising serial clock; address bits only counted, never stored
// - accepted suspend sets suspend flag immediately
`timescale 1ns/1ps
module fri_cmd #(
	parameter logic [7:0]  MFR_ID         = 8'h5a,
	parameter logic [7:0]  DEV_ID         = 8'h15,
	parameter logic [7:0]  MEM_TYPE       = 8'h60,
	parameter logic [7:0]  CAPACITY       = 8'h16,
	parameter logic [63:0] UNIQUE_ID      = 64'h0123_4567_89ab_cdef,
	parameter int          PD_ENTRY_CYC   = fri_pkg::PD_ENTRY_CYC,
	parameter int          PD_RELEASE_CYC = fri_pkg::PD_RELEASE_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       sclk,
	input  wire logic       csN,
	input  wire logic [3:0] ioIn,
	output logic      [3:0] ioOut,
	output logic      [3:0] ioOe,
	input  wire logic       coreBusy,
	input  wire logic       powerFail,
	output logic            resumeStart,
	output logic            suspendStart,
	output logic            busyFlag,
	output logic            suspendFlag,
	output logic            powerDown
);
	// id parameters above carry arbitrary values

	if (PD_ENTRY_CYC < 1 || PD_ENTRY_CYC > 65535) begin : g_bad_entry
		$error("PD_ENTRY_CYC out of range");
	end
	if (PD_RELEASE_CYC < 1 || PD_RELEASE_CYC > 65535) begin : g_bad_release
		$error("PD_RELEASE_CYC out of range");
	end

	localparam logic [15:0] ENTRY_LAST   = 16'(PD_ENTRY_CYC - 1);
	localparam logic [15:0] RELEASE_LAST = 16'(PD_RELEASE_CYC - 1);

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	logic [5:0] pinS;
	logic       sclkS;
	logic       csS;
	logic [3:0] ioS;
	logic       sclkPrev_q;
	logic       rise;
	logic       fall;
	logic       csRise;
	logic       csPrev_q;

	fri_sync #(
		.W       (6),
		.RST_VAL (fri_pkg::PIN_RST)
	) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  ({sclk, csN, ioIn}),
		.dout (pinS)
	);

	assign sclkS  = pinS[5];
	assign csS    = pinS[4];
	assign ioS    = pinS[3:0];
	assign rise   = sclkS & ~sclkPrev_q & ~csS;
	assign fall   = ~sclkS & sclkPrev_q & ~csS;
	assign csRise = csS & ~csPrev_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			sclkPrev_q <= 1'b0;
			csPrev_q   <= 1'b1;
		end else begin
			sclkPrev_q <= sclkS;
			csPrev_q   <= csS;
		end
	end

	// ------------------------------------------------------------
	// bit count and opcode capture
	// ------------------------------------------------------------
	logic [6:0] bitCnt_q;
	logic [7:0] opcode_q;
	logic [7:0] opNow;
	logic       decode;

	assign opNow  = {opcode_q[6:0], ioS[0]};
	assign decode = rise && bitCnt_q == fri_pkg::OPC_BITS - 7'h01;

	always_ff @(posedge clk) begin
		if (rst || csS) begin
			bitCnt_q <= 7'h00;
		end else if (rise && bitCnt_q != 7'h7f) begin
			bitCnt_q <= bitCnt_q + 7'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			opcode_q <= 8'h00;
		end else if (rise && bitCnt_q < fri_pkg::OPC_BITS) begin
			opcode_q <= opNow;
		end
	end

	// ------------------------------------------------------------
	// suspend / resume flags
	// ------------------------------------------------------------
	fri_pkg::fri_pwr_t pwr_q;
	logic              exec;
	logic              resumeOk;
	logic              suspendOk;
	logic              resumePend_q;

	assign busyFlag  = coreBusy | resumePend_q;
	// frame of exactly one opcode byte, acted on at chip select rise
	assign exec      = csRise && bitCnt_q == fri_pkg::OPC_BITS && pwr_q == fri_pkg::PW_ACTIVE;
	assign resumeOk  = exec && opcode_q == fri_pkg::OP_RESUME && suspendFlag && !busyFlag;
	assign suspendOk = exec && opcode_q == fri_pkg::OP_SUSPEND && !suspendFlag && busyFlag;

	always_ff @(posedge clk) begin
		if (rst) begin
			suspendFlag <= 1'b0;
		end else if (suspendOk) begin
			suspendFlag <= 1'b1;
		end else if (resumeOk || powerFail) begin
			suspendFlag <= 1'b0;
		end
	end

	// busy shows on the edge after acceptance, well inside 200 ns
	always_ff @(posedge clk) begin
		if (rst) begin
			resumePend_q <= 1'b0;
		end else if (resumeOk) begin
			resumePend_q <= 1'b1;
		end else if (coreBusy || powerFail) begin
			resumePend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			resumeStart  <= 1'b0;
			suspendStart <= 1'b0;
		end else begin
			resumeStart  <= resumeOk;
			suspendStart <= suspendOk;
		end
	end

	// ------------------------------------------------------------
	// power-down sequencing
	// ------------------------------------------------------------
	logic [15:0] pwrCnt_q;
	logic        releaseOk;

	assign releaseOk = csRise && bitCnt_q == fri_pkg::OPC_BITS && opcode_q == fri_pkg::OP_RELEASE
		&& (pwr_q == fri_pkg::PW_ENTER || pwr_q == fri_pkg::PW_DOWN) && !busyFlag;
	assign powerDown = pwr_q == fri_pkg::PW_DOWN;

	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_q    <= fri_pkg::PW_ACTIVE;
			pwrCnt_q <= 16'h0000;
		end else begin
			case (pwr_q)
				fri_pkg::PW_ACTIVE: begin
					pwrCnt_q <= 16'h0000;
					if (exec && opcode_q == fri_pkg::OP_PWR_DOWN) begin
						pwr_q <= fri_pkg::PW_ENTER;
					end
				end
				fri_pkg::PW_ENTER: begin
					if (releaseOk) begin
						pwr_q    <= fri_pkg::PW_RELEASE;
						pwrCnt_q <= 16'h0000;
					end else if (pwrCnt_q == ENTRY_LAST) begin
						pwr_q <= fri_pkg::PW_DOWN;
					end else begin
						pwrCnt_q <= pwrCnt_q + 16'h0001;
					end
				end
				fri_pkg::PW_DOWN: begin
					pwrCnt_q <= 16'h0000;
					if (releaseOk) begin
						pwr_q <= fri_pkg::PW_RELEASE;
					end
				end
				fri_pkg::PW_RELEASE: begin
					if (pwrCnt_q == RELEASE_LAST) begin
						pwr_q <= fri_pkg::PW_ACTIVE;
					end else begin
						pwrCnt_q <= pwrCnt_q + 16'h0001;
					end
				end
				default: begin
					pwr_q <= fri_pkg::PW_ACTIVE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// id read decode
	// ------------------------------------------------------------
	fri_pkg::fri_cmd_t cmd_q;
	logic [63:0]       pat_q;
	logic [6:0]        len_q;
	logic [6:0]        lanes_q;
	logic [6:0]        start_q;
	logic [3:0]        oeMask_q;
	logic              idOk;

	// outside normal operation no id read is served; only entry and power-down hear the release
	always_comb begin
		idOk = 1'b0;
		if (pwr_q == fri_pkg::PW_ACTIVE) begin
			case (opNow)
				fri_pkg::OP_RELEASE: idOk = !busyFlag;
				fri_pkg::OP_ID_MD,
				fri_pkg::OP_ID_DUAL,
				fri_pkg::OP_ID_QUAD,
				fri_pkg::OP_UID,
				fri_pkg::OP_JEDEC:   idOk = 1'b1;
				default:             idOk = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst || csS) begin
			cmd_q <= fri_pkg::CM_OPCODE;
		end else begin
			case (cmd_q)
				fri_pkg::CM_OPCODE: begin
					if (decode) begin
						cmd_q <= idOk ? fri_pkg::CM_WAIT : fri_pkg::CM_IGNORE;
					end
				end
				fri_pkg::CM_WAIT: begin
					if (fall && bitCnt_q >= start_q) begin
						cmd_q <= fri_pkg::CM_DATA;
					end
				end
				fri_pkg::CM_DATA:   cmd_q <= fri_pkg::CM_DATA;
				fri_pkg::CM_IGNORE: cmd_q <= fri_pkg::CM_IGNORE;
				default:            cmd_q <= fri_pkg::CM_IGNORE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pat_q    <= 64'h0;
			len_q    <= fri_pkg::LEN_8;
			lanes_q  <= fri_pkg::LANES_1;
			start_q  <= fri_pkg::START_JD;
			oeMask_q <= fri_pkg::OE_1;
		end else if (decode && cmd_q == fri_pkg::CM_OPCODE) begin
			len_q    <= fri_pkg::LEN_16;
			lanes_q  <= fri_pkg::LANES_1;
			oeMask_q <= fri_pkg::OE_1;
			pat_q    <= {MFR_ID, DEV_ID, 48'h0};
			start_q  <= fri_pkg::START_MD;
			case (opNow)
				fri_pkg::OP_RELEASE: begin
					pat_q   <= {DEV_ID, 56'h0};
					len_q   <= fri_pkg::LEN_8;
					start_q <= fri_pkg::START_AB;
				end
				fri_pkg::OP_ID_DUAL: begin
					lanes_q  <= fri_pkg::LANES_2;
					oeMask_q <= fri_pkg::OE_2;
					start_q  <= fri_pkg::START_DL;
				end
				fri_pkg::OP_ID_QUAD: begin
					lanes_q  <= fri_pkg::LANES_4;
					oeMask_q <= fri_pkg::OE_4;
					start_q  <= fri_pkg::START_QD;
				end
				fri_pkg::OP_UID: begin
					pat_q   <= UNIQUE_ID;
					len_q   <= fri_pkg::LEN_64;
					start_q <= fri_pkg::START_UID;
				end
				fri_pkg::OP_JEDEC: begin
					pat_q   <= {MFR_ID, MEM_TYPE, CAPACITY, 40'h0};
					len_q   <= fri_pkg::LEN_24;
					start_q <= fri_pkg::START_JD;
				end
				default: begin
					start_q <= fri_pkg::START_MD;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// output shifter
	// ------------------------------------------------------------
	logic [6:0]  pos_q;
	logic [6:0]  posNext;
	logic [63:0] patShift;
	logic [3:0]  nib;
	logic        drive;

	assign drive    = fall && (cmd_q == fri_pkg::CM_DATA
		|| (cmd_q == fri_pkg::CM_WAIT && bitCnt_q >= start_q));
	assign patShift = pat_q << pos_q;
	assign nib      = patShift[63:60];
	assign posNext  = pos_q + lanes_q;

	always_ff @(posedge clk) begin
		if (rst || csS) begin
			pos_q <= 7'h00;
		end else if (drive) begin
			// wrapping keeps the pattern repeating while clocks run
			pos_q <= (posNext >= len_q) ? 7'h00 : posNext;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || csS) begin
			ioOut <= 4'h0;
			ioOe  <= 4'h0;
		end else if (drive) begin
			ioOe <= oeMask_q;
			case (lanes_q)
				fri_pkg::LANES_1: ioOut <= {2'b00, nib[3], 1'b0};
				fri_pkg::LANES_2: ioOut <= {2'b00, nib[3:2]};
				default:          ioOut <= nib;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_resume_gate;
		@(posedge clk) disable iff (rst)
		resumeStart |-> $past(suspendFlag) && !$past(busyFlag);
	endproperty
	a_resume_gate: assert property (p_resume_gate) else $error("resume taken in wrong state");

	property p_resume_effect;
		@(posedge clk) disable iff (rst)
		resumeStart |-> !suspendFlag && busyFlag;
	endproperty
	a_resume_effect: assert property (p_resume_effect) else $error("resume did not clear flag or set busy");

	property p_power_loss;
		@(posedge clk) disable iff (rst)
		powerFail && !suspendOk |=> !suspendFlag ##1 !resumeStart;
	endproperty
	a_power_loss: assert property (p_power_loss) else $error("suspend survived power loss");

	property p_pd_entry;
		@(posedge clk) disable iff (rst)
		$changed(pwr_q) && pwr_q == fri_pkg::PW_ENTER
			|-> $past(opcode_q) == fri_pkg::OP_PWR_DOWN && $past(bitCnt_q) == fri_pkg::OPC_BITS;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power-down entered without clean B9h");

	property p_pd_time;
		@(posedge clk) disable iff (rst)
		pwr_q == fri_pkg::PW_ENTER && pwrCnt_q == ENTRY_LAST && !releaseOk |=> pwr_q == fri_pkg::PW_DOWN;
	endproperty
	a_pd_time: assert property (p_pd_time) else $error("power-down entry too slow");

	property p_pd_quiet;
		@(posedge clk) disable iff (rst)
		pwr_q != fri_pkg::PW_ACTIVE |-> ioOe == 4'h0 && !resumeStart && !suspendStart;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("command served while powered down");

	property p_start_active;
		@(posedge clk) disable iff (rst)
		$fell(rst) |-> pwr_q == fri_pkg::PW_ACTIVE;
	endproperty
	a_start_active: assert property (p_start_active) else $error("not in normal operation after reset");

	property p_release_delay;
		@(posedge clk) disable iff (rst)
		$past(pwr_q) == fri_pkg::PW_RELEASE && pwr_q == fri_pkg::PW_ACTIVE |-> $past(pwrCnt_q) == RELEASE_LAST;
	endproperty
	a_release_delay: assert property (p_release_delay) else $error("release delay cut short");

	property p_busy_ignore;
		@(posedge clk) disable iff (rst)
		decode && cmd_q == fri_pkg::CM_OPCODE && opNow == fri_pkg::OP_RELEASE && busyFlag
			|=> cmd_q == fri_pkg::CM_IGNORE;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("ABh served while busy");

	property p_suspend_set;
		@(posedge clk) disable iff (rst)
		suspendStart |-> suspendFlag && !$past(suspendFlag);
	endproperty
	a_suspend_set: assert property (p_suspend_set) else $error("suspend flag not set");

endmodule : fri_cmd

/* File: fri_host.sv */
// host serial controller model that drives command frames into the block
`timescale 1ns/1ps
module fri_host #(
	parameter int H = 6
) (
	input  wire logic       clk,
	output logic            sclk,
	output logic            csN,
	output logic      [3:0] ioIn,
	input  wire logic [3:0] ioOut,
	input  wire logic [3:0] ioOe
);
	initial begin
		sclk = 1'b0;
		csN  = 1'b1;
		ioIn = 4'h0;
	end

	// ------------------------------------------------------------
	// one frame: opcode, zero address or dummy, then data phase
	// ------------------------------------------------------------
	task automatic frame(input logic [7:0] op, input int nRise, input int nData, input int lanes,
		output logic [63:0] got, output logic [3:0] oe);
		int         i;
		logic [3:0] s;
		got = '0;
		oe  = '0;
		@(posedge clk);
		csN <= 1'b0;
		for (i = 0; i < nRise + nData; i++) begin
			// zero address bits; released lanes toggle so stale values never match
			if (i < 8) ioIn <= {3'h0, op[7 - i]};
			// dual and quad mode byte carries f in its upper nibble
			else if (lanes == 2 && (i == nRise - 4 || i == nRise - 3)) ioIn <= 4'h3;
			else if (lanes == 4 && i == nRise - 2) ioIn <= 4'hf;
			else if (i < nRise) ioIn <= 4'h0;
			else ioIn <= ~ioIn;
			repeat (H) @(posedge clk);
			sclk <= 1'b1;
			if (i >= nRise) begin
				s   = (lanes == 1) ? {3'h0, ioOut[1]} : (lanes == 2) ? {2'h0, ioOut[1:0]} : ioOut;
				got = (got << lanes) | {60'h0, s};
				oe  = ioOe;
			end
			repeat (H) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (H) @(posedge clk);
		csN  <= 1'b1;
		ioIn <= ~ioIn;
		repeat (H) @(posedge clk);
	endtask : frame
endmodule : fri_host

/* File: fri_cmd_tb.sv */
// self-checking testbench for the resume, power-down and id command block
`timescale 1ns/1ps
module fri_cmd_tb;
	localparam int          PD_CYC = 4;
	// identity values are arbitrary
	localparam logic [7:0]  MFR    = 8'h5a;
	localparam logic [7:0]  DEV    = 8'h15;
	localparam logic [7:0]  MEMT   = 8'h60;
	localparam logic [7:0]  CAP    = 8'h16;
	localparam logic [63:0] UID    = 64'h0123_4567_89ab_cdef;

	typedef struct {
		logic [7:0]  op;
		int          nRise;
		int          nData;
		int          lanes;
		logic [63:0] exp;
		logic [3:0]  oe;
	} fri_row_t;

	logic        clk;
	logic        rst;
	logic        sclk;
	logic        csN;
	logic [3:0]  ioIn;
	logic [3:0]  ioOut;
	logic [3:0]  ioOe;
	logic        coreBusy;
	logic        powerFail;
	logic        resumeStart;
	logic        suspendStart;
	logic        busyFlag;
	logic        suspendFlag;
	logic        powerDown;
	int          n_fail      = 0;
	int          check_count = 0;
	int          nRes        = 0;
	int          nSus        = 0;
	int          i;
	fri_row_t    rows[7];
	logic [63:0] got;
	logic [3:0]  oe;

	fri_cmd #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MEMT), .CAPACITY(CAP), .UNIQUE_ID(UID),
		.PD_ENTRY_CYC(PD_CYC), .PD_RELEASE_CYC(PD_CYC)) dut_u (
		.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
		.coreBusy(coreBusy), .powerFail(powerFail), .resumeStart(resumeStart),
		.suspendStart(suspendStart), .busyFlag(busyFlag), .suspendFlag(suspendFlag), .powerDown(powerDown));

	fri_host host_u (.clk(clk), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// counts the one-cycle engine pulses
	always @(posedge clk) begin
		if (resumeStart === 1'b1) nRes++;
		if (suspendStart === 1'b1) nSus++;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic waitPd(input logic lvl, input int lim);
		int k;
		check_count++;
		for (k = 0; k < lim; k++) begin
			if (powerDown === lvl) return;
			@(posedge clk);
		end
		n_fail++;
		$display("CHECK FAILED at %0t: seen %h expected %h", $time, powerDown, lvl);
		results();
	endtask : waitPd

	task automatic send(input logic [7:0] op, input int nRise, input int nData);
		host_u.frame(op, nRise, nData, 1, got, oe);
	endtask : send

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst       = 1'b1;
		coreBusy  = 1'b0;
		powerFail = 1'b0;
		rows[0] = '{fri_pkg::OP_JEDEC, 8, 48, 1, {16'h0, MFR, MEMT, CAP, MFR, MEMT, CAP}, 4'h2};
		rows[1] = '{fri_pkg::OP_RELEASE, 32, 16, 1, {48'h0, DEV, DEV}, 4'h2};
		rows[2] = '{fri_pkg::OP_ID_MD, 32, 32, 1, {32'h0, MFR, DEV, MFR, DEV}, 4'h2};
		rows[3] = '{fri_pkg::OP_ID_DUAL, 24, 16, 2, {32'h0, MFR, DEV, MFR, DEV}, 4'h3};
		rows[4] = '{fri_pkg::OP_ID_QUAD, 20, 16, 4, {4{MFR, DEV}}, 4'hf};
		rows[5] = '{fri_pkg::OP_UID, 40, 64, 1, UID, 4'h2};
		rows[6] = '{8'h00, 8, 8, 1, 64'h0, 4'h0};
		cyc(4);
		rst <= 1'b0;
		cyc(2);
		chk(powerDown, 1'b0);
		chk(suspendFlag, 1'b0);
		chk(ioOe, 4'h0);
		$display("test reset done");

		for (i = 0; i < 7; i++) begin
			host_u.frame(rows[i].op, rows[i].nRise, rows[i].nData, rows[i].lanes, got, oe);
			chk(got, rows[i].exp);
			chk(oe, rows[i].oe);
		end
		$display("test id reads done");

		send(fri_pkg::OP_PWR_DOWN, 9, 0);
		cyc(PD_CYC + 8);
		chk(powerDown, 1'b0);
		send(fri_pkg::OP_PWR_DOWN, 8, 0);
		waitPd(1'b1, PD_CYC + 16);
		send(fri_pkg::OP_JEDEC, 8, 8);
		chk(oe, 4'h0);
		chk(powerDown, 1'b1);
		send(fri_pkg::OP_RELEASE, 8, 0);
		waitPd(1'b0, 20);
		cyc(PD_CYC + 4);
		send(fri_pkg::OP_JEDEC, 8, 8);
		chk(got, {56'h0, MFR});
		$display("test power-down done");

		coreBusy <= 1'b1;
		send(fri_pkg::OP_RESUME, 8, 0);
		chk(nRes, 0);
		send(fri_pkg::OP_SUSPEND, 8, 0);
		chk(nSus, 1);
		chk(suspendFlag, 1'b1);
		send(fri_pkg::OP_RESUME, 8, 0);
		chk(nRes, 0);
		coreBusy <= 1'b0;
		cyc(2);
		send(fri_pkg::OP_RESUME, 8, 0);
		chk(nRes, 1);
		chk(suspendFlag, 1'b0);
		chk(busyFlag, 1'b1);
		send(fri_pkg::OP_RELEASE, 32, 8);
		chk(oe, 4'h0);
		chk(busyFlag, 1'b1);
		coreBusy <= 1'b1;
		cyc(2);
		coreBusy <= 1'b0;
		cyc(2);
		chk(busyFlag, 1'b0);
		send(fri_pkg::OP_RESUME, 8, 0);
		chk(nRes, 1);
		$display("test resume done");

		cyc(fri_pkg::RESUME_BUSY_CYC);
		coreBusy <= 1'b1;
		send(fri_pkg::OP_SUSPEND, 8, 0);
		chk(suspendFlag, 1'b1);
		coreBusy  <= 1'b0;
		powerFail <= 1'b1;
		cyc(1);
		powerFail <= 1'b0;
		cyc(2);
		chk(suspendFlag, 1'b0);
		send(fri_pkg::OP_RESUME, 8, 0);
		chk(nRes, 1);
		$display("test power loss done");

		send(fri_pkg::OP_PWR_DOWN, 8, 0);
		waitPd(1'b1, PD_CYC + 16);
		rst <= 1'b1;
		cyc(4);
		rst <= 1'b0;
		cyc(2);
		chk(powerDown, 1'b0);
		$display("test second reset done");
		results();
	end
endmodule : fri_cmd_tb
